// ===== core/hdpc_port_ctrl.sv
// Hub repeater control for four downstream ports with APB registers
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "hdpc_consts.svh"

//
// Overview of operation
// - Both lines low means no connect
// - Generate EOP on ports at EOF1
// - Low-speed attach sets connect bit, interrupt
// - Full-speed attach sets connect bit, interrupt
// - Connect needs non-SE0 beyond 2.5 us
// - SE0 2.0-2.5 us clears bit, interrupts
// - Connect bits 0-3, upper bits zero
// - Resets clear connect status, then re-detect
// - Speed bits per port, cleared by resets
// - Enable bits per port, cleared by resets
// - Enabled ports receive and repeat traffic
// - No full-speed traffic to low-speed ports
// - Enable waits for current packet end
// - Suspended hub still interrupts on events
// - Babble at EOF2 clears enable bit
// - Two-bit forcing field, chip reset clears
// - Forced lines use port speed edge rate
// - Bus reset keeps forcing field
// - Forcing codes none, one, zero, SE0
module hdpc_port_ctrl (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	// APB slave
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	// Hub and frame events
	input wire logic I_USB_BUS_RESET,
	input wire logic I_HUB_SUSPEND,
	input wire logic I_EOF1,
	input wire logic I_EOF2,
	input wire logic I_UP_PKT_ACTIVE,
	input wire logic I_UP_FS_PKT,
	input wire logic I_HUB_IRQ_ACK,
	output logic O_HUB_IRQ,
	output logic O_EOP_GEN,
	// Downstream lines
	input wire logic [3:0] I_DP,
	input wire logic [3:0] I_DM,
	output logic [3:0] O_DP_OUT,
	output logic [3:0] O_DM_OUT,
	output logic [3:0] O_D_OE_N,
	output logic [3:0] O_SLOW_EDGE,
	// Repeater gating
	output logic [3:0] O_PORT_RX_EN,
	output logic [3:0] O_PORT_TX_EN
);
	hdpc_pkg::hdpc_core_s r;
	hdpc_pkg::hdpc_core_s n;
	logic [3:0] conn_evt;
	logic [3:0] disc_evt;
	logic [3:0] line_idle;
	logic [3:0] line_se0;
	logic [3:0] babble;
	logic setup;
	logic wr_acc;
	logic mapped;
	logic [7:0] rd_mux;
	logic [7:0] wv;

	// Address match against a register index
	function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
		reg_hit = (addr == {2'b00, idx, 2'b00});
	endfunction : reg_hit

	// Forcing code to driven D+ level
	function automatic logic force_dp(input logic [1:0] code);
		force_dp = (code == `HDPC_FORCE_DIFF1);
	endfunction : force_dp

	// Forcing code to driven D- level
	function automatic logic force_dm(input logic [1:0] code);
		force_dm = (code == `HDPC_FORCE_DIFF0);
	endfunction : force_dm

	// One duration filter per port
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			hdpc_line_filter u_filt (
				.i_clk(I_CORE_CLK),
				.i_reset_n(I_RESET_N),
				.i_clr(I_USB_BUS_RESET),
				.i_dp(r.dp[gi]),
				.i_dm(r.dm[gi]),
				.i_attached(r.attach[gi]),
				.o_conn(conn_evt[gi]),
				.o_disc(disc_evt[gi])
			);
			// Idle is J: D+ high at full speed, D- high at low speed
			assign line_idle[gi] = r.speed[gi] ? (!r.dp[gi] && r.dm[gi]) : (r.dp[gi] && !r.dm[gi]);
			assign line_se0[gi] = !r.dp[gi] && !r.dm[gi];
		end
	endgenerate

	// Babble: non-idle line or open upstream path at EOF2
	assign babble = r.enable & (~line_idle | r.up_conn);

	// APB phase decode
	assign setup = I_PSEL && !I_PENABLE;
	assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE && r.pready;
	assign wv = I_PWDATA[7:0];
	assign mapped = reg_hit(I_PADDR, `HDPC_IDX_ATTACH) || reg_hit(I_PADDR, `HDPC_IDX_GATE) ||
		reg_hit(I_PADDR, `HDPC_IDX_RATE) || reg_hit(I_PADDR, `HDPC_IDX_FORCE) ||
		reg_hit(I_PADDR, `HDPC_IDX_HUBCTL);

	// Read data mux; reserved bits read zero
	always_comb begin
		rd_mux = 8'h00;
		if (reg_hit(I_PADDR, `HDPC_IDX_ATTACH)) begin
			rd_mux = {4'h0, r.attach};
		end else if (reg_hit(I_PADDR, `HDPC_IDX_GATE)) begin
			rd_mux = {4'h0, r.enable};
		end else if (reg_hit(I_PADDR, `HDPC_IDX_RATE)) begin
			rd_mux = {4'h0, r.speed};
		end else if (reg_hit(I_PADDR, `HDPC_IDX_FORCE)) begin
			rd_mux = r.force_f;
		end else if (reg_hit(I_PADDR, `HDPC_IDX_HUBCTL)) begin
			rd_mux = {6'h00, r.irq_flag, r.irq_en};
		end
	end

	// Next-state logic
	always_comb begin
		n = r;
		// Two-stage synchronisers on the line inputs
		n.sync1_dp = I_DP;
		n.sync1_dm = I_DM;
		n.dp = r.sync1_dp;
		n.dm = r.sync1_dm;

		// Zero-wait APB answer, prepared in the setup cycle
		n.pready = setup;
		n.pslverr = setup && !mapped;
		n.prdata = (setup && !I_PWRITE) ? rd_mux : 8'h00;

		// Register writes
		if (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_ATTACH)) begin
			n.attach = wv[3:0];
		end
		if (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_RATE)) begin
			n.speed = wv[3:0];
		end
		if (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_FORCE)) begin
			n.force_f = wv;
		end
		if (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_HUBCTL)) begin
			n.irq_en = wv[`HDPC_HUBCTL_IRQ_EN];
		end
		// Disable acts at once, enable is parked until the bus is free
		if (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_GATE)) begin
			n.enable = r.enable & wv[3:0];
			n.en_pend = wv[3:0] & ~r.enable;
		end
		if (!I_UP_PKT_ACTIVE) begin
			n.enable = n.enable | n.en_pend;
			n.en_pend = 4'h0;
		end

		// Upstream path from a port opens on K and closes on EOP
		for (int i = 0; i < 4; i++) begin
			if (!r.enable[i] || line_se0[i]) begin
				n.up_conn[i] = 1'b0;
			end else if (!line_idle[i]) begin
				n.up_conn[i] = 1'b1;
			end
		end

		// Babble kills the port and any parked enable
		if (I_EOF2) begin
			n.enable = n.enable & ~babble;
			n.en_pend = n.en_pend & ~babble;
		end

		// Filter events win over a same-cycle software write
		n.attach = (n.attach | conn_evt) & ~disc_evt;

		// Sticky flag, set wins over acknowledge; events count when suspended too
		n.irq_flag = (r.irq_flag && !I_HUB_IRQ_ACK &&
			!(wr_acc && reg_hit(I_PADDR, `HDPC_IDX_HUBCTL) && wv[`HDPC_HUBCTL_IRQ_FLAG])) ||
			(|(conn_evt | disc_evt));

		// Bus reset clears status but never the forcing field
		if (I_USB_BUS_RESET) begin
			n.attach = 4'(`HDPC_RST_VAL);
			n.speed = 4'(`HDPC_RST_VAL);
			n.enable = 4'(`HDPC_RST_VAL);
			n.en_pend = 4'(`HDPC_RST_VAL);
			n.up_conn = 4'(`HDPC_RST_VAL);
		end

		// Registered outputs, built from next-state values; EOP straight from I_EOF1
		n.irq = n.irq_flag && n.irq_en;
		n.eop = I_EOF1;
		for (int i = 0; i < 4; i++) begin
			n.dp_out[i] = force_dp(n.force_f[2*i +: 2]);
			n.dm_out[i] = force_dm(n.force_f[2*i +: 2]);
			n.oe_n[i] = (n.force_f[2*i +: 2] == `HDPC_FORCE_NONE);
		end
		// Edge rate follows the programmed port speed
		n.slow_edge = n.speed;
		// Low-speed ports are blanked during full-speed packets
		n.rx_en = n.enable & ~{4{I_HUB_SUSPEND}} & ~(n.speed & {4{I_UP_FS_PKT}});
		n.tx_en = n.enable & ~{4{I_HUB_SUSPEND}};
	end

	// State register, synchronous reset
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			r <= '0;
			// Lines are released in reset, so no device sees a forced SE0
			r.oe_n <= 4'hF;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign O_PREADY = r.pready;
	assign O_PRDATA = {24'h000000, r.prdata};
	assign O_PSLVERR = r.pslverr;
	assign O_HUB_IRQ = r.irq;
	assign O_EOP_GEN = r.eop;
	assign O_DP_OUT = r.dp_out;
	assign O_DM_OUT = r.dm_out;
	assign O_D_OE_N = r.oe_n;
	assign O_SLOW_EDGE = r.slow_edge;
	assign O_PORT_RX_EN = r.rx_en;
	assign O_PORT_TX_EN = r.tx_en;

	// Checks on the control logic
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);

	a_eop_at_eof1: assert property (I_EOF1 |=> O_EOP_GEN && $past(I_EOF1))
		else $error("EOP not generated after EOF1");

	a_conn_sets_bit: assert property ((|conn_evt) && !I_USB_BUS_RESET |=>
		((r.attach & $past(conn_evt)) == $past(conn_evt)) ##1 O_HUB_IRQ || !r.irq_en)
		else $error("Connect did not set status or interrupt");

	a_disc_clears: assert property ((|disc_evt) |=> ((r.attach & $past(disc_evt)) == 4'h0) && r.irq_flag)
		else $error("Disconnect did not clear status");

	a_irq_held: assert property (r.irq_flag && !I_HUB_IRQ_ACK && !wr_acc |=> r.irq_flag)
		else $error("Interrupt flag dropped without acknowledge");

	a_bus_rst_clear: assert property (I_USB_BUS_RESET |=>
		(r.attach == 4'h0) && (r.enable == 4'h0) && (r.speed == 4'h0))
		else $error("Bus reset left status set");

	a_force_kept: assert property (I_USB_BUS_RESET && !wr_acc |=> r.force_f == $past(r.force_f))
		else $error("Bus reset changed forcing field");

	a_ls_blocked: assert property (I_UP_FS_PKT |=> (O_PORT_RX_EN & r.speed) == 4'h0)
		else $error("Full-speed traffic sent to low-speed port");

	a_babble_disable: assert property (I_EOF2 && (|babble) && !wr_acc |=> (r.enable & $past(babble)) == 4'h0)
		else $error("Babbling port left enabled");

	a_enable_defer: assert property (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_GATE) && I_UP_PKT_ACTIVE |=>
		(r.enable & ~$past(r.enable)) == 4'h0)
		else $error("Enable applied during packet");

	a_force_se0: assert property (r.force_f[7:6] == `HDPC_FORCE_SE0 && !wr_acc |=>
		!O_D_OE_N[3] && !O_DP_OUT[3] && !O_DM_OUT[3])
		else $error("SE0 forcing not driven on port 4");

	a_rsvd_zero: assert property (setup && !I_PWRITE && reg_hit(I_PADDR, `HDPC_IDX_ATTACH) |=>
		O_PRDATA[31:4] == 28'h0000000)
		else $error("Reserved connect bits not zero");

	// End of packet lasts no longer than EOF1
	a_eop_single: assert property (!I_EOF1 |=> !O_EOP_GEN)
		else $error("EOP generated without EOF1");

	// Acknowledge with no new event clears the flag
	a_ack_clears: assert property (I_HUB_IRQ_ACK && !(|conn_evt) && !(|disc_evt) |=> !r.irq_flag)
		else $error("Acknowledge did not clear interrupt flag");

	// Interrupt line is the enabled flag
	a_irq_level: assert property (O_HUB_IRQ == (r.irq_flag && r.irq_en))
		else $error("Interrupt line differs from enabled flag");

	// Traffic only flows on enabled ports
	a_rx_enabled_only: assert property (((O_PORT_RX_EN | O_PORT_TX_EN) & ~r.enable) == 4'h0)
		else $error("Traffic gated open on disabled port");

	// A suspended hub repeats nothing
	a_suspend_gates: assert property (I_HUB_SUSPEND |=> (O_PORT_RX_EN | O_PORT_TX_EN) == 4'h0)
		else $error("Traffic gated open while suspended");

	// An enable written on an idle bus takes hold at once
	a_enable_idle: assert property (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_GATE) && !I_UP_PKT_ACTIVE &&
		!I_EOF2 && !I_USB_BUS_RESET |=> r.enable == $past(wv[3:0]))
		else $error("Enable not applied on idle bus");

	// Bus reset closes every port and drops parked enables
	a_bus_rst_off: assert property (I_USB_BUS_RESET |=> O_PORT_TX_EN == 4'h0 && r.en_pend == 4'h0)
		else $error("Port left open after bus reset");

	// A cleared forcing field drives nothing
	a_force_released: assert property (r.force_f == 8'h00 && !wr_acc |=> O_D_OE_N == 4'hF)
		else $error("Line driven with forcing cleared");

	// Edge rate always tracks the speed bits
	a_slow_follows: assert property (O_SLOW_EDGE == r.speed)
		else $error("Edge rate differs from port speed");

	// Upper speed bits read zero
	a_rate_rsvd: assert property (setup && !I_PWRITE && reg_hit(I_PADDR, `HDPC_IDX_RATE) |=>
		O_PRDATA[31:4] == 28'h0000000)
		else $error("Reserved speed bits not zero");

	// Differential one on port 2
	a_force_diff1: assert property (r.force_f[3:2] == `HDPC_FORCE_DIFF1 && !wr_acc |=>
		!O_D_OE_N[1] && O_DP_OUT[1] && !O_DM_OUT[1])
		else $error("Differential one not driven on port 2");

	// Differential zero on port 3
	a_force_diff0: assert property (r.force_f[5:4] == `HDPC_FORCE_DIFF0 && !wr_acc |=>
		!O_D_OE_N[2] && !O_DP_OUT[2] && O_DM_OUT[2])
		else $error("Differential zero not driven on port 3");

	// Main scenarios worth seeing in a run
	c_connect: cover property ((|conn_evt) ##1 O_HUB_IRQ);
	c_babble: cover property (I_EOF2 && (|babble));
	c_enable_defer: cover property (wr_acc && reg_hit(I_PADDR, `HDPC_IDX_GATE) && I_UP_PKT_ACTIVE);
	c_disconnect: cover property (|disc_evt);
	c_eop: cover property (I_EOF1 ##1 O_EOP_GEN);
endmodule : hdpc_port_ctrl
`default_nettype wire

// ===== inc/hdpc_consts.svh
// Constants for the hub downstream port control block
`ifndef HDPC_CONSTS_SVH
`define HDPC_CONSTS_SVH

// Register indices; byte address is four times the index
`define HDPC_IDX_ATTACH 8'h48
`define HDPC_IDX_GATE 8'h49
`define HDPC_IDX_RATE 8'h4A
`define HDPC_IDX_FORCE 8'h4C
`define HDPC_IDX_HUBCTL 8'h51

// Field positions in the hub control register
`define HDPC_HUBCTL_IRQ_EN 0
`define HDPC_HUBCTL_IRQ_FLAG 1

// Bus reset value of connect, speed and enable bits
`define HDPC_RST_VAL 8'h00

// Forcing field codes
`define HDPC_FORCE_NONE 2'h0
`define HDPC_FORCE_DIFF1 2'h1
`define HDPC_FORCE_DIFF0 2'h2
`define HDPC_FORCE_SE0 2'h3

// Timing: clock period and filter times in ns
`define HDPC_CLK_NS 10
`define HDPC_CONN_NS 2500
`define HDPC_DISC_MIN_NS 2000
// Connect needs strictly more than the time; disconnect rounds the least time up
`define HDPC_CONN_CYC (`HDPC_CONN_NS / `HDPC_CLK_NS + 1)
`define HDPC_DISC_CYC ((`HDPC_DISC_MIN_NS + `HDPC_CLK_NS - 1) / `HDPC_CLK_NS)
`define HDPC_CNT_MAX 9'h1FF

`endif

// ===== inc/hdpc_pkg.sv
// Types of the hub downstream port control block
package hdpc_pkg;

	// State of the main control logic
	typedef struct packed {
		logic [3:0] sync1_dp;
		logic [3:0] sync1_dm;
		logic [3:0] dp;
		logic [3:0] dm;
		logic [3:0] attach;
		logic [3:0] enable;
		logic [3:0] en_pend;
		logic [3:0] speed;
		logic [7:0] force_f;
		logic irq_en;
		logic irq_flag;
		logic [3:0] up_conn;
		logic pready;
		logic pslverr;
		logic [7:0] prdata;
		logic eop;
		logic irq;
		logic [3:0] rx_en;
		logic [3:0] tx_en;
		logic [3:0] dp_out;
		logic [3:0] dm_out;
		logic [3:0] oe_n;
		logic [3:0] slow_edge;
	} hdpc_core_s;

	// State of one line duration filter
	typedef struct packed {
		logic [8:0] cnt;
		logic se0;
		logic conn;
		logic disc;
	} hdpc_filt_s;

endpackage : hdpc_pkg

// ===== core/hdpc_line_filter.sv
// Connect and disconnect duration filter for one downstream port
`timescale 1ns/1ps
`default_nettype none
`include "hdpc_consts.svh"

module hdpc_line_filter (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Restart after bus reset
	input wire logic i_clr,
	// Synchronised line levels and current status
	input wire logic i_dp,
	input wire logic i_dm,
	input wire logic i_attached,
	// One-cycle events
	output logic o_conn,
	output logic o_disc
);
	hdpc_pkg::hdpc_filt_s r;
	hdpc_pkg::hdpc_filt_s n;
	logic se0;

	// Both lines low is SE0, also the no-connect state
	assign se0 = !i_dp && !i_dm;

	// Counter restarts on each change of line class
	always_comb begin
		n = r;
		n.se0 = se0;
		if (i_clr || (se0 != r.se0)) begin
			n.cnt = 9'h000;
		end else if (r.cnt != `HDPC_CNT_MAX) begin
			n.cnt = r.cnt + 9'h001;
		end
		// Saturation means each event fires only once per class run
		n.conn = !i_clr && !se0 && !i_attached && (r.cnt == 9'(`HDPC_CONN_CYC));
		n.disc = !i_clr && se0 && i_attached && (r.cnt == 9'(`HDPC_DISC_CYC));
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_conn = r.conn;
	assign o_disc = r.disc;
endmodule : hdpc_line_filter
`default_nettype wire

// ===== testbench/hdpc_usb_dev_model.sv
// Behavioural model of the USB devices on the four downstream ports
`timescale 1ns/1ps
`default_nettype none

module hdpc_usb_dev_model (
	// Device presence, speed and misbehaviour per port
	input wire logic [3:0] i_attached,
	input wire logic [3:0] i_low_speed,
	input wire logic [3:0] i_babble,
	// Levels the hub drives while forcing
	input wire logic [3:0] i_dp_out,
	input wire logic [3:0] i_dm_out,
	input wire logic [3:0] i_oe_n,
	// Resolved line levels
	output logic [3:0] o_dp,
	output logic [3:0] o_dm
);
	// Hub drive wins; a detached port is held low by the pull-downs
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			if (!i_oe_n[p]) begin
				o_dp[p] = i_dp_out[p];
				o_dm[p] = i_dm_out[p];
			end else if (i_attached[p]) begin
				// Idle J from the pull-up side; babble shows K instead
				o_dp[p] = ~i_low_speed[p] ^ i_babble[p];
				o_dm[p] = i_low_speed[p] ^ i_babble[p];
			end else begin
				o_dp[p] = 1'b0;
				o_dm[p] = 1'b0;
			end
		end
	end
endmodule : hdpc_usb_dev_model
`default_nettype wire

// ===== testbench/hdpc_port_ctrl_tb.sv
// Self-checking bench for the hub downstream port control block
`timescale 1ns/1ps
`default_nettype none
`include "hdpc_consts.svh"

module hdpc_port_ctrl_tb;
	localparam logic [11:0] A_ATT = 12'(4 * `HDPC_IDX_ATTACH);
	localparam logic [11:0] A_GATE = 12'(4 * `HDPC_IDX_GATE);
	localparam logic [11:0] A_RATE = 12'(4 * `HDPC_IDX_RATE);
	localparam logic [11:0] A_FRC = 12'(4 * `HDPC_IDX_FORCE);
	localparam logic [11:0] A_CTL = 12'(4 * `HDPC_IDX_HUBCTL);
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic breset = 0, susp = 0, eof1 = 0, eof2 = 0, pkt = 0, fs = 0, ack = 0;
	logic [3:0] att = '0, low = '0, bab = '0;
	logic [3:0] dp, dm, dpo, dmo, oe_n, slow, rxen, txen;
	logic rdy, err, irq, eop;
	logic [31:0] prdata;
	int bad_count = 0;
	int n_compared = 0;

	// Core clock, 10 ns period
	initial forever #5 clk = ~clk;

	hdpc_port_ctrl i_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(rdy), .O_PRDATA(prdata),
		.O_PSLVERR(err), .I_USB_BUS_RESET(breset), .I_HUB_SUSPEND(susp), .I_EOF1(eof1), .I_EOF2(eof2),
		.I_UP_PKT_ACTIVE(pkt), .I_UP_FS_PKT(fs), .I_HUB_IRQ_ACK(ack), .O_HUB_IRQ(irq), .O_EOP_GEN(eop),
		.I_DP(dp), .I_DM(dm), .O_DP_OUT(dpo), .O_DM_OUT(dmo), .O_D_OE_N(oe_n), .O_SLOW_EDGE(slow),
		.O_PORT_RX_EN(rxen), .O_PORT_TX_EN(txen));

	hdpc_usb_dev_model i_dev (.i_attached(att), .i_low_speed(low), .i_babble(bab), .i_dp_out(dpo),
		.i_dm_out(dmo), .i_oe_n(oe_n), .o_dp(dp), .o_dm(dm));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// One APB transfer; the slave must answer in the first access cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1);
		cmp(n, 1);
		rd = prdata;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic e;
		apb(1'b1, a, d, rd, e);
		cmp(e, 0);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] rd;
		logic e;
		apb(1'b0, a, 32'h0, rd, e);
		cmp(rd, exp);
		cmp(e, ee);
	endtask : rdc

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// Watchdog; the whole sequence needs under 2000 cycles
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end

	// Test sequence
	initial begin
		cyc(10);
		rst_n <= 1'b1;
		rdc(A_ATT, 0, 0);
		rdc(A_GATE, 0, 0);
		rdc(A_FRC, 0, 0);
		wr(A_RATE, 32'hFF);
		rdc(A_RATE, 32'h0F, 0);
		rdc(12'h200, 0, 1);
		wr(A_CTL, 32'h01);
		done("reset");
		att <= 4'h3;
		low <= 4'h2;
		cyc(245);
		rdc(A_ATT, 0, 0);
		cyc(20);
		rdc(A_ATT, 32'h03, 0);
		cmp(irq, 1);
		ack <= 1'b1;
		cyc(1);
		ack <= 1'b0;
		cyc(2);
		cmp(irq, 0);
		done("connect");
		wr(A_RATE, 32'h02);
		cyc(2);
		cmp(slow, 4'h2);
		pkt <= 1'b1;
		fs <= 1'b1;
		wr(A_GATE, 32'h03);
		cyc(3);
		cmp(txen, 0);
		pkt <= 1'b0;
		cyc(3);
		cmp(txen, 4'h3);
		cmp(rxen, 4'h1);
		done("enable");
		// Port 2 leaves while the hub sleeps
		susp <= 1'b1;
		att <= 4'h1;
		cyc(3);
		cmp(txen, 0);
		cyc(190);
		rdc(A_ATT, 32'h03, 0);
		cyc(60);
		rdc(A_ATT, 32'h01, 0);
		cmp(irq, 1);
		susp <= 1'b0;
		done("disconnect");
		// Idle at the frame end keeps the port, K traffic loses it
		wr(A_GATE, 32'h01);
		cyc(3);
		eof2 <= 1'b1;
		cyc(1);
		eof2 <= 1'b0;
		rdc(A_GATE, 32'h01, 0);
		bab <= 4'h1;
		cyc(4);
		eof2 <= 1'b1;
		cyc(1);
		eof2 <= 1'b0;
		rdc(A_GATE, 0, 0);
		bab <= 4'h0;
		eof1 <= 1'b1;
		cyc(1);
		eof1 <= 1'b0;
		#1 cmp(eop, 1);
		cyc(1);
		#1 cmp(eop, 0);
		done("frame");
		wr(A_FRC, 32'hE4);
		cyc(2);
		cmp(oe_n, 4'h1);
		cmp(dpo, 4'h2);
		cmp(dmo, 4'h4);
		breset <= 1'b1;
		cyc(3);
		breset <= 1'b0;
		rdc(A_ATT, 0, 0);
		rdc(A_RATE, 0, 0);
		rdc(A_FRC, 32'hE4, 0);
		wr(A_FRC, 32'h00);
		cyc(270);
		rdc(A_ATT, 32'h01, 0);
		done("bus reset");
		wr(A_GATE, 32'h01);
		wr(A_FRC, 32'h24);
		rst_n <= 1'b0;
		cyc(10);
		rst_n <= 1'b1;
		rdc(A_FRC, 0, 0);
		rdc(A_GATE, 0, 0);
		done("chip reset");
		stop_test();
	end
endmodule : hdpc_port_ctrl_tb
`default_nettype wire
